// [tcc_defines.svh]
/*
 * register map, field positions, reset values and timing counts of the timer core.
 * assumes: included by the core and the bench.
 */
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
`define TCC_A_CTRL 8'h00
`define TCC_A_CLR 8'h04
`define TCC_A_SET 8'h05
`define TCC_A_EVC 8'h06
`define TCC_A_DBG 8'h08
`define TCC_A_FLAG 8'h0E
`define TCC_A_STAT 8'h0F
`define TCC_A_COUNT 8'h10
`define TCC_A_PER 8'h14
`define TCC_B_SRST 0
`define TCC_B_EN 1
`define TCC_B_STBY 11
`define TCC_B_DIR 0
`define TCC_B_SINGLE 2
`define TCC_B_WEO 8
`define TCC_B_STOP 3
`define TCC_B_SLAVE 4
`define TCC_B_BUSY 7
`define TCC_PER_RST 8'hFF
`define TCC_TOP16 16'hFFFF
`define TCC_SYNC_CYC 2'h2
`endif

// [tcc_pkg.sv]
/*
 * types of the timer core: width, resync policy, command, run state.
 * assumes: nothing beyond the defines header.
 */
package tcc_pkg;
    typedef enum logic [1:0] {TCC_W16 = 2'h0, TCC_W8 = 2'h1, TCC_W32 = 2'h2} tcc_width_t;
    typedef enum logic [1:0] {TCC_RS_GCLK = 2'h0, TCC_RS_PRESC = 2'h1,
                              TCC_RS_RESYNC = 2'h2} tcc_resync_t;
    typedef enum logic [1:0] {TCC_CMD_NONE = 2'h0, TCC_CMD_RETRIG = 2'h1,
                              TCC_CMD_STOP = 2'h2} tcc_cmd_t;
    typedef enum logic [1:0] {TCC_OFF, TCC_RUN, TCC_STOP} tcc_run_t;
    typedef logic [2:0] tcc_evact_t;
    localparam tcc_evact_t TCC_EVA_COUNT = 3'h2;
endpackage

// [tcc_timer_core.sv]
/*
 * counting engine of one timer unit: register port, prescaler, counter,
 * wrap flag and event, stop command, pairing for 32-bit width.
 * assumes: count_tick_in is a one-cycle pulse per shared count clock edge,
 * already brought into sys_clk_in; the pair partner is wired by the top.
 */
`timescale 1ns/1ps
`include "tcc_defines.svh"
module tcc_timer_core #(
    parameter bit IS_ODD = 1'b0 // odd member of a pair
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [15:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [15:0] rd_data_out,
    input wire logic count_tick_in,
    input wire logic event_in,
    input wire logic debug_halt_in,
    input wire logic guard_lock_in,
    input wire logic ext_debug_access_in,
    input wire logic pair_mode_in,
    input wire logic pair_carry_in,
    input wire logic pair_dir_in,
    input wire logic pair_limit_in,
    output logic pair_mode_out,
    output logic pair_carry_out,
    output logic pair_dir_out,
    output logic pair_limit_out,
    output logic wrap_event_out,
    output logic [1:0] wave_out
);
    import tcc_pkg::*;

    // control state
    logic enable_r; // running permission
    tcc_width_t width_r; // width_select
    logic [1:0] wave_kind_r; // waveform_kind_select, stored only
    logic [2:0] div_sel_r; // divider_select
    tcc_resync_t resync_r; // divider_resync_select
    logic standby_r; // run_in_standby, stored only
    logic dir_r; // 1 = down
    logic single_r; // single run
    tcc_evact_t evact_r; // event_action_field
    logic weo_r; // wrap_event_output_enable
    logic dbg_run_r; // debug_run_control
    logic wrap_flag_r; // wrap_flag
    logic [7:0] per_r; // top_limit_reg
    logic [15:0] count_r; // bus-visible count
    logic [15:0] hi_r; // slave high half, never on the bus
    tcc_run_t state_r;
    logic [9:0] presc_r; // prescaler counter
    logic presc_tog_r; // prescaler output toggle
    logic [1:0] sync_cnt_r; // write sync in flight
    logic [15:0] rd_nxt;

    // divider select to terminal count
    function automatic logic [9:0] div_limit(input logic [2:0] sel);
        logic [9:0] r;
        r = 10'h000;
        unique case (sel)
            3'h0: r = 10'h000;
            3'h1: r = 10'h001;
            3'h2: r = 10'h003;
            3'h3: r = 10'h007;
            3'h4: r = 10'h00F;
            3'h5: r = 10'h03F;
            3'h6: r = 10'h0FF;
            3'h7: r = 10'h3FF;
        endcase
        return r;
    endfunction

    // guard lock lifted under halt or debugger access
    wire guard_ok = !guard_lock_in || debug_halt_in || ext_debug_access_in;
    wire wr_ctrl = wr_en_in && addr_in == `TCC_A_CTRL && guard_ok;
    wire srst = wr_ctrl && wr_data_in[`TCC_B_SRST];
    wire wr_set = wr_en_in && addr_in == `TCC_A_SET && guard_ok;
    wire wr_clr = wr_en_in && addr_in == `TCC_A_CLR && guard_ok;
    wire wr_evc = wr_en_in && addr_in == `TCC_A_EVC && guard_ok;
    wire wr_dbg = wr_en_in && addr_in == `TCC_A_DBG && guard_ok;
    // flag, count and period stay writable under lock
    wire wr_flag = wr_en_in && addr_in == `TCC_A_FLAG;
    wire wr_cnt = wr_en_in && addr_in == `TCC_A_COUNT;
    wire wr_per = wr_en_in && addr_in == `TCC_A_PER;
    wire [1:0] cmd = wr_set ? wr_data_in[7:6] : 2'h0;
    wire cmd_stop = cmd == TCC_CMD_STOP;
    wire cmd_retrig = cmd == TCC_CMD_RETRIG;

    // slave when odd and the even partner runs 32-bit
    wire is_slave = IS_ODD && pair_mode_in;
    wire halted = debug_halt_in && !dbg_run_r;
    wire running = state_r == TCC_RUN && !halted && !is_slave;
    wire ev_mode = evact_r == TCC_EVA_COUNT;
    wire presc_hit = count_tick_in && presc_r == div_limit(div_sel_r);
    wire [15:0] top = width_r == TCC_W8 ? {8'h00, per_r} : `TCC_TOP16;
    wire at_limit = dir_r ? count_r == 16'h0000 : count_r == top;
    // at the limit, gclk resync wraps on the raw tick
    wire wrap_on_gclk = at_limit && resync_r != TCC_RS_PRESC && div_sel_r != 3'h0;
    wire tick_src = wrap_on_gclk ? count_tick_in : presc_hit;
    wire step = running && (ev_mode ? event_in : tick_src);
    wire roll = step && at_limit;
    wire ovf = roll && (width_r != TCC_W32 || pair_limit_in);

    // control register fields
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            enable_r <= 1'b0;
            width_r <= TCC_W16;
            wave_kind_r <= 2'h0;
            div_sel_r <= 3'h0;
            resync_r <= TCC_RS_GCLK;
            standby_r <= 1'b0;
        end else if (srst) begin
            enable_r <= 1'b0;
            width_r <= TCC_W16;
            wave_kind_r <= 2'h0;
            div_sel_r <= 3'h0;
            resync_r <= TCC_RS_GCLK;
            standby_r <= 1'b0;
        end else if (wr_ctrl) begin
            enable_r <= wr_data_in[`TCC_B_EN];
            standby_r <= wr_data_in[`TCC_B_STBY];
            // old enable low covers the enabling write too
            if (!enable_r) begin
                width_r <= tcc_width_t'(wr_data_in[3:2]);
                wave_kind_r <= wr_data_in[6:5];
                div_sel_r <= wr_data_in[10:8];
                resync_r <= tcc_resync_t'(wr_data_in[13:12]);
            end
        end
    end

    // direction, single run, event control
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dir_r <= 1'b0;
            single_r <= 1'b0;
            evact_r <= 3'h0;
            weo_r <= 1'b0;
        end else if (srst) begin
            dir_r <= 1'b0;
            single_r <= 1'b0;
            evact_r <= 3'h0;
            weo_r <= 1'b0;
        end else begin
            // set side wins if both in one access pattern
            if (wr_clr && wr_data_in[`TCC_B_DIR]) begin
                dir_r <= 1'b0;
            end
            if (wr_set && wr_data_in[`TCC_B_DIR]) begin
                dir_r <= 1'b1;
            end
            if (wr_clr && wr_data_in[`TCC_B_SINGLE]) begin
                single_r <= 1'b0;
            end
            if (wr_set && wr_data_in[`TCC_B_SINGLE]) begin
                single_r <= 1'b1;
            end
            if (wr_evc) begin
                weo_r <= wr_data_in[`TCC_B_WEO];
                if (!enable_r) begin
                    evact_r <= wr_data_in[2:0];
                end
            end
        end
    end

    // debug control survives soft reset
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dbg_run_r <= 1'b0;
        end else if (wr_dbg) begin
            dbg_run_r <= wr_data_in[0];
        end
    end

    // run state: off, running, stopped
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= TCC_OFF;
        end else if (srst || (wr_ctrl && !wr_data_in[`TCC_B_EN])) begin
            state_r <= TCC_OFF;
        end else begin
            unique case (state_r)
                TCC_OFF: begin
                    if (wr_ctrl && wr_data_in[`TCC_B_EN]) begin
                        state_r <= TCC_RUN;
                    end
                end
                TCC_RUN: begin
                    if (cmd_stop || (ovf && single_r)) begin
                        state_r <= TCC_STOP;
                    end
                end
                TCC_STOP: begin
                    if (cmd_retrig) begin
                        state_r <= TCC_RUN;
                    end
                end
            endcase
        end
    end

    // prescaler: counts raw ticks, toggles its output at the end
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            presc_r <= 10'h000;
            presc_tog_r <= 1'b0;
        end else if (srst || !running || ev_mode) begin
            presc_r <= 10'h000;
        end else if (ovf && resync_r == TCC_RS_RESYNC) begin
            presc_r <= 10'h000;
        end else if (presc_hit) begin
            presc_r <= 10'h000;
            presc_tog_r <= !presc_tog_r;
        end else if (count_tick_in) begin
            presc_r <= presc_r + 10'h001;
        end
    end

    // counter; stop and halt simply withhold the step
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_r <= 16'h0000;
        end else if (srst) begin
            count_r <= 16'h0000;
        end else if (wr_cnt) begin
            count_r <= width_r == TCC_W8 ? {8'h00, wr_data_in[7:0]} : wr_data_in;
        end else if (roll) begin
            count_r <= dir_r ? top : 16'h0000;
        end else if (step) begin
            count_r <= dir_r ? count_r - 16'h0001 : count_r + 16'h0001;
        end
    end

    // slave high half steps on the master carry only
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hi_r <= 16'h0000;
            pair_limit_out <= 1'b0;
        end else begin
            if (!is_slave) begin
                hi_r <= 16'h0000;
            end else if (pair_carry_in) begin
                hi_r <= pair_dir_in ? hi_r - 16'h0001 : hi_r + 16'h0001;
            end
            pair_limit_out <= is_slave && (pair_dir_in ? hi_r == 16'h0000 : hi_r == `TCC_TOP16);
        end
    end

    // pair links are registered, carry lands one cycle late
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pair_mode_out <= 1'b0;
            pair_carry_out <= 1'b0;
            pair_dir_out <= 1'b0;
        end else begin
            pair_mode_out <= !IS_ODD && width_r == TCC_W32;
            pair_carry_out <= roll && width_r == TCC_W32;
            pair_dir_out <= dir_r;
        end
    end

    // wrap flag: set wins over a clearing write
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wrap_flag_r <= 1'b0;
            wrap_event_out <= 1'b0;
        end else begin
            if (ovf) begin
                wrap_flag_r <= 1'b1;
            end else if (srst || (wr_flag && wr_data_in[0])) begin
                wrap_flag_r <= 1'b0;
            end
            wrap_event_out <= ovf && weo_r;
        end
    end

    // waveform: bit 0 toggles per wrap, cleared outside the run state
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wave_out <= 2'h0;
        end else if (srst || cmd_stop || state_r != TCC_RUN) begin
            wave_out <= 2'h0;
        end else if (ovf) begin
            wave_out <= {1'b0, !wave_out[0]};
        end
    end

    // period register and write-sync busy
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            per_r <= `TCC_PER_RST;
            sync_cnt_r <= 2'h0;
        end else begin
            if (srst) begin
                per_r <= `TCC_PER_RST;
            end else if (wr_per) begin
                per_r <= wr_data_in[7:0];
            end
            // busy covers the hop into the count domain
            if (wr_cnt || wr_ctrl) begin
                sync_cnt_r <= `TCC_SYNC_CYC;
            end else if (sync_cnt_r != 2'h0) begin
                sync_cnt_r <= sync_cnt_r - 2'h1;
            end
        end
    end

    // read mux; unmapped reads return zero
    always_comb begin
        rd_nxt = 16'h0000;
        unique case (addr_in)
            `TCC_A_CTRL: rd_nxt = {2'h0, resync_r, standby_r, div_sel_r, 1'b0,
                                   wave_kind_r, 1'b0, width_r, enable_r, 1'b0};
            `TCC_A_CLR, `TCC_A_SET: rd_nxt = {13'h0000, single_r, 1'b0, dir_r};
            `TCC_A_EVC: rd_nxt = {7'h00, weo_r, 5'h00, evact_r};
            `TCC_A_DBG: rd_nxt = {15'h0000, dbg_run_r};
            `TCC_A_FLAG: rd_nxt = {15'h0000, wrap_flag_r};
            `TCC_A_STAT: rd_nxt = {8'h00, sync_cnt_r != 2'h0, 2'h0, is_slave,
                                   state_r == TCC_STOP, 3'h0};
            `TCC_A_COUNT: rd_nxt = count_r;
            `TCC_A_PER: rd_nxt = width_r == TCC_W8 ? {8'h00, per_r} : 16'h0000;
            default: rd_nxt = 16'h0000;
        endcase
    end

    // read data stands the cycle after the strobe only
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= 16'h0000;
        end else begin
            rd_data_out <= rd_en_in ? rd_nxt : 16'h0000;
        end
    end

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    wrap_flag_set_a: assert property (ovf |=> wrap_flag_r)
        else $error("wrap did not set flag");
    wrap_event_a: assert property (wrap_event_out == $past(ovf && weo_r))
        else $error("wrap event mismatch");
    soft_reset_a: assert property (srst |=> state_r == TCC_OFF && !enable_r)
        else $error("soft reset left timer enabled");
    stop_freeze_a: assert property (state_r == TCC_STOP && !wr_cnt |=> $stable(count_r))
        else $error("stopped counter moved");
    stop_cmd_a: assert property (cmd_stop && state_r == TCC_RUN && !wr_ctrl
        |=> wave_out == 2'h0 && state_r == TCC_STOP)
        else $error("stop command not applied");
    halt_freeze_a: assert property (halted && !wr_cnt && !srst |=> $stable(count_r))
        else $error("count moved under debug halt");
    guard_lock_a: assert property (wr_en_in && addr_in == `TCC_A_DBG && !guard_ok
        |=> $stable(dbg_run_r))
        else $error("locked write took effect");
    enable_protect_a: assert property (enable_r && wr_ctrl && !srst |=> $stable(width_r))
        else $error("width changed while enabled");
    up_wrap_a: assert property (roll && !dir_r && !wr_cnt && !srst |=> count_r == 16'h0000)
        else $error("up count did not wrap to zero");
    down_wrap_a: assert property (roll && dir_r && !wr_cnt && !srst && !wr_per
        |=> count_r == $past(top))
        else $error("down count did not wrap to top");
    cv_wrap_c: cover property (ovf && weo_r);
    cv_stop_c: cover property (cmd_stop && state_r == TCC_RUN);
    cv_down_c: cover property (roll && dir_r);
    cv_slave_c: cover property (is_slave && pair_carry_in);
endmodule

// [tcc_event_source.sv]
/*
 * far-side model: the shared count clock edges and the event system, as
 * bursts of one-cycle pulses on the tick line or on the event line.
 * assumes: one system clock; the bench asks for a burst with a go pulse.
 */
`timescale 1ns/1ps
module tcc_event_source (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic go_in,
    input wire logic use_event_in,
    input wire logic [7:0] count_in,
    input wire logic [3:0] gap_in,
    output logic tick_out,
    output logic event_out,
    output logic busy_out
);
    logic [7:0] left_r; // pulses still owed
    logic [3:0] wait_r; // idle cycles before the next pulse
    logic event_r; // burst goes to the event line
    logic fire; // a pulse leaves this cycle

    assign fire = (left_r != 8'h00) && (wait_r == 4'h0);
    assign busy_out = (left_r != 8'h00);

    // pacing; gap 0 answers promptly, a larger gap plays a slow clock
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            left_r <= 8'h00;
            wait_r <= 4'h0;
            event_r <= 1'b0;
        end else if (go_in) begin
            left_r <= count_in;
            wait_r <= gap_in;
            event_r <= use_event_in;
        end else if (fire) begin
            left_r <= left_r - 8'h01;
            wait_r <= gap_in;
        end else if (wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
        end
    end

    // one tick stream feeds the whole pair, already brought into sys clock
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_out <= 1'b0;
            event_out <= 1'b0;
        end else begin
            tick_out <= fire && !event_r;
            event_out <= fire && event_r;
        end
    end
endmodule

// [tcc_timer_core_bench.sv]
/*
 * self-checking bench of the timer core: register port tasks, one task per
 * scenario, pulse source as far side.
 * assumes: an even/odd pair shares the port and the pulses, links wired across;
 * the odd one is read on its own data line only.
 */
`timescale 1ns/1ps
`include "tcc_defines.svh"
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); end end
module tcc_timer_core_bench;
    import tcc_pkg::*;
    logic clk = 1'b0; // system clock, 8 ns
    logic rst = 1'b1; // async reset
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [15:0] rdata_odd; // read data of the odd partner
    logic even_mode, even_carry, even_dir, even_limit; // links even to odd
    logic odd_mode, odd_carry, odd_dir, odd_limit; // links odd to even
    logic tick;
    logic evt;
    logic halt = 1'b0; // cpu debug halt
    logic lock = 1'b0; // access guard lock
    logic extdbg = 1'b0; // access from external debugger
    logic go = 1'b0;
    logic use_ev = 1'b0;
    logic [7:0] n = 8'h00;
    logic busy;
    logic wrap_ev;
    logic [1:0] wave;
    int err_count = 0;
    int tests_run = 0;
    int ev_seen = 0; // wrap event pulses seen

    always #4 clk = ~clk;

    tcc_event_source src_u (.sys_clk_in(clk), .rst_in(rst), .go_in(go), .use_event_in(use_ev),
        .count_in(n), .gap_in(4'h2), .tick_out(tick), .event_out(evt), .busy_out(busy));

    tcc_timer_core #(.IS_ODD(1'b0)) dut_u (.sys_clk_in(clk), .rst_in(rst), .addr_in(addr),
        .wr_data_in(wdata), .wr_en_in(wr), .rd_en_in(rd), .rd_data_out(rdata),
        .count_tick_in(tick), .event_in(evt), .debug_halt_in(halt), .guard_lock_in(lock),
        .ext_debug_access_in(extdbg), .pair_mode_in(odd_mode), .pair_carry_in(odd_carry),
        .pair_dir_in(odd_dir), .pair_limit_in(odd_limit), .pair_mode_out(even_mode),
        .pair_carry_out(even_carry), .pair_dir_out(even_dir), .pair_limit_out(even_limit),
        .wrap_event_out(wrap_ev), .wave_out(wave));

    // odd partner on the same port; slave once the even side runs 32-bit
    tcc_timer_core #(.IS_ODD(1'b1)) dut_odd_u (.sys_clk_in(clk), .rst_in(rst), .addr_in(addr),
        .wr_data_in(wdata), .wr_en_in(wr), .rd_en_in(rd), .rd_data_out(rdata_odd),
        .count_tick_in(tick), .event_in(evt), .debug_halt_in(halt), .guard_lock_in(lock),
        .ext_debug_access_in(extdbg), .pair_mode_in(even_mode), .pair_carry_in(even_carry),
        .pair_dir_in(even_dir), .pair_limit_in(even_limit), .pair_mode_out(odd_mode),
        .pair_carry_out(odd_carry), .pair_dir_out(odd_dir), .pair_limit_out(odd_limit),
        .wrap_event_out(), .wave_out());

    // count event pulses; each must be a single cycle
    always @(posedge clk) begin
        if (wrap_ev === 1'b1) ev_seen++;
    end

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        // taken at the edge that closes the data cycle, before it is replaced
        @(posedge clk);
        `CHK(what, exp, rdata)
    endtask

    // burst of pulses, bounded wait, then time for the count to land
    task automatic pulses(input logic [7:0] cnt, input logic on_event);
        int i;
        @(posedge clk);
        go <= 1'b1;
        n <= cnt;
        use_ev <= on_event;
        @(posedge clk);
        go <= 1'b0;
        i = 0;
        do begin
            @(posedge clk);
            #1;
            i++;
        end while (busy && i < 400);
        repeat (3) @(posedge clk);
    endtask

    task automatic soft_reset();
        wr_reg(`TCC_A_CTRL, 16'h0000);
        wr_reg(`TCC_A_CTRL, 16'h0001);
        repeat (3) @(posedge clk);
    endtask

    task automatic t_reset();
        rd_chk(`TCC_A_CTRL, 16'h0000, "ctrl");
        rd_chk(`TCC_A_PER, 16'h0000, "period16");
        rd_chk(8'h30, 16'h0000, "unmapped");
        rd_chk(`TCC_A_COUNT, 16'h0000, "count");
        $display("test reset done");
    endtask

    task automatic t_wrap();
        wr_reg(`TCC_A_EVC, 16'h0100);
        wr_reg(`TCC_A_COUNT, 16'hFFFE);
        wr_reg(`TCC_A_CTRL, 16'h0002);
        rd_chk(`TCC_A_COUNT, 16'hFFFE, "count kept");
        pulses(8'h02, 1'b0);
        rd_chk(`TCC_A_COUNT, 16'h0000, "count up wrap");
        rd_chk(`TCC_A_FLAG, 16'h0001, "flag");
        `CHK("wrap events", 1, ev_seen)
        `CHK("wave", 2'b01, wave)
        wr_reg(`TCC_A_FLAG, 16'h0001);
        rd_chk(`TCC_A_FLAG, 16'h0000, "flag clear");
        wr_reg(`TCC_A_CTRL, 16'h0000);
        pulses(8'h03, 1'b0);
        rd_chk(`TCC_A_COUNT, 16'h0000, "count off");
        $display("test wrap done");
    endtask

    task automatic t_down();
        soft_reset();
        wr_reg(`TCC_A_SET, 16'h0001);
        wr_reg(`TCC_A_CTRL, 16'h0002);
        pulses(8'h01, 1'b0);
        rd_chk(`TCC_A_COUNT, 16'hFFFF, "count down wrap");
        rd_chk(`TCC_A_FLAG, 16'h0001, "flag down");
        wr_reg(`TCC_A_CLR, 16'h0001);
        pulses(8'h02, 1'b0);
        rd_chk(`TCC_A_COUNT, 16'h0001, "count up again");
        $display("test direction done");
    endtask

    task automatic t_protect();
        soft_reset();
        wr_reg(`TCC_A_CTRL, 16'h0006);
        rd_chk(`TCC_A_CTRL, 16'h0006, "width with enable");
        rd_chk(`TCC_A_PER, 16'h00FF, "period8");
        wr_reg(`TCC_A_CTRL, 16'h0002);
        rd_chk(`TCC_A_CTRL, 16'h0006, "width while on");
        wr_reg(`TCC_A_CTRL, 16'h0000);
        rd_chk(`TCC_A_CTRL, 16'h0004, "width on disable");
        lock <= 1'b1;
        wr_reg(`TCC_A_DBG, 16'h0001);
        rd_chk(`TCC_A_DBG, 16'h0000, "locked dbg");
        wr_reg(`TCC_A_COUNT, 16'h0012);
        rd_chk(`TCC_A_COUNT, 16'h0012, "locked count");
        halt <= 1'b1;
        wr_reg(`TCC_A_DBG, 16'h0001);
        rd_chk(`TCC_A_DBG, 16'h0001, "halt unlocks");
        halt <= 1'b0;
        extdbg <= 1'b1;
        wr_reg(`TCC_A_DBG, 16'h0000);
        rd_chk(`TCC_A_DBG, 16'h0000, "debugger unlocks");
        extdbg <= 1'b0;
        lock <= 1'b0;
        $display("test protection done");
    endtask

    task automatic t_debug();
        soft_reset();
        wr_reg(`TCC_A_CTRL, 16'h0002);
        halt <= 1'b1;
        pulses(8'h03, 1'b0);
        rd_chk(`TCC_A_COUNT, 16'h0000, "halted count");
        wr_reg(`TCC_A_DBG, 16'h0001);
        pulses(8'h03, 1'b0);
        rd_chk(`TCC_A_COUNT, 16'h0003, "debug run count");
        halt <= 1'b0;
        soft_reset();
        rd_chk(`TCC_A_DBG, 16'h0001, "dbg survives");
        rd_chk(`TCC_A_CTRL, 16'h0000, "ctrl after reset");
        rd_chk(`TCC_A_COUNT, 16'h0000, "count after reset");
        wr_reg(`TCC_A_DBG, 16'h0000);
        $display("test debug and reset done");
    endtask

    // dividers 1, 2, 4 and 8 over eight raw ticks give eight divided by their factor
    task automatic t_presc();
        for (int s = 0; s < 4; s++) begin
            soft_reset();
            wr_reg(`TCC_A_CTRL, 16'h0002 | (16'(s) << 8));
            pulses(8'h08, 1'b0);
            rd_chk(`TCC_A_COUNT, 16'h0008 >> s, "divided count");
        end
        soft_reset();
        wr_reg(`TCC_A_EVC, 16'h0002);
        wr_reg(`TCC_A_CTRL, 16'h0702);
        pulses(8'h05, 1'b1);
        pulses(8'h03, 1'b0);
        rd_chk(`TCC_A_COUNT, 16'h0005, "event count");
        $display("test prescaler and events done");
    endtask

    task automatic t_stop();
        soft_reset();
        wr_reg(`TCC_A_COUNT, 16'h0040);
        wr_reg(`TCC_A_CTRL, 16'h0002);
        pulses(8'h02, 1'b0);
        wr_reg(`TCC_A_SET, 16'h0080);
        pulses(8'h03, 1'b0);
        rd_chk(`TCC_A_COUNT, 16'h0042, "stopped count");
        rd_chk(`TCC_A_STAT, 16'h0008, "stopped status");
        `CHK("stopped wave", 2'b00, wave)
        $display("test stop done");
    endtask

    // 32-bit pair: the even low half rolls into the odd slave's high half
    task automatic t_w32();
        soft_reset();
        wr_reg(`TCC_A_COUNT, 16'hFFFE);
        wr_reg(`TCC_A_CTRL, 16'h000A);
        rd_chk(`TCC_A_STAT, 16'h0080, "sync busy");
        `CHK("slave status", 16'h0090, rdata_odd)
        pulses(8'h02, 1'b0);
        rd_chk(`TCC_A_COUNT, 16'h0000, "low half roll");
        `CHK("slave count", 16'hFFFE, rdata_odd)
        rd_chk(`TCC_A_FLAG, 16'h0000, "no 32-bit wrap");
        $display("test 32-bit pair done");
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog well past the few hundred cycles the tests need
    initial begin
        #400000;
        err_count++;
        test_done();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_wrap();
        t_down();
        t_protect();
        t_debug();
        t_presc();
        t_stop();
        t_w32();
        test_done();
    end
endmodule
